// >>> adc_ctrl_cfg.svh
// constants of the converter control block: timing counts, register map, fields, reset values
// assumes a 50 MHz system clock and is included by bare name
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

// clock rate in MHz (period 20 ns)
`define ADC_CLK_MHZ 50
// time spent on one trial bit, in ns
`define ADC_BIT_TIME_NS 800
`define ADC_BIT_CYCLES ((`ADC_BIT_TIME_NS * `ADC_CLK_MHZ) / 1000)
// full and short cycles must finish within 10 us and 8 us
`define ADC_CONV12_MAX_NS 10000
`define ADC_CONV8_MAX_NS 8000
`define ADC_CONV12_MAX_CYCLES ((`ADC_CONV12_MAX_NS * `ADC_CLK_MHZ) / 1000)
`define ADC_CONV8_MAX_CYCLES ((`ADC_CONV8_MAX_NS * `ADC_CLK_MHZ) / 1000)
// acquisition interval after the last bit, least time, rounded up
`define ADC_ACQ_TIME_NS 800
`define ADC_ACQ_CYCLES ((`ADC_ACQ_TIME_NS * `ADC_CLK_MHZ + 999) / 1000)
// bit counts of the two cycle lengths; lowest bit index tested
`define ADC_FULL_BITS 12
`define ADC_SHORT_BITS 8
`define ADC_FULL_LAST_BIT 4'h0
`define ADC_SHORT_LAST_BIT 4'h4
`define ADC_MSB_INDEX 4'hB
`define ADC_MSB_TRIAL 12'h800

// register offsets on the 4-bit register port
`define ADC_REG_CTRL 4'h0
`define ADC_REG_STATUS 4'h4
`define ADC_REG_MASK 4'h8
`define ADC_REG_RESULT 4'hC
// control fields
`define ADC_CTRL_STANDALONE 0
// event fields of status and mask
`define ADC_EV_DONE 0
`define ADC_EV_START 1
`define ADC_EV_IGNORED 2
// result register: valid flag position
`define ADC_RESULT_VALID 15
// reset values
`define ADC_CTRL_RST 1'b0
`define ADC_EV_RST 3'h0
`define ADC_RESULT_RST 12'h000

`endif

// >>> adc_ctrl_pkg.sv
// types shared by the converter control block and its approximation sequencer
// assumes adc_ctrl_cfg.svh holds every number
package adc_ctrl_pkg;

  // host-facing control sequence
  typedef enum logic [2:0]
  {
    ST_IDLE    = 3'b001,
    ST_CONVERT = 3'b010,
    ST_ACQUIRE = 3'b100
  } ctrl_state_e;

  // approximation sequencer
  typedef enum logic [1:0]
  {
    SAR_IDLE = 2'b01,
    SAR_RUN  = 2'b10
  } sar_state_e;

  typedef logic [11:0] result_t;
  typedef logic [2:0]  event_t;

endpackage

// >>> adc_sar_sequencer.sv
// successive approximation sequencer: one trial bit per divider enable, msb first
// assumes comp_keep_i is the comparator verdict for the bit currently on trial
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"

module adc_sar_sequencer
  import adc_ctrl_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    sys_rst_i,
  input  wire logic    start_i,
  input  wire logic    short_i,
  input  wire logic    comp_keep_i,
  output logic         busy_o,
  output logic         done_o,
  output result_t      result_o
);

  typedef struct packed
  {
    sar_state_e  state;
    logic [3:0]  bit_idx;
    logic [3:0]  last_bit;
    logic [5:0]  div_cnt;
    result_t     approx;
    logic        done;
  } sar_s;

  sar_s s_reg;
  sar_s s_next;
  logic bit_en;

  // divider enable: one trial bit per enable
  assign bit_en = (s_reg.div_cnt == 6'(`ADC_BIT_CYCLES - 1));

  // next state; a start while running is never seen here, the caller filters it
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    case (s_reg.state)
      SAR_IDLE:
      begin
        if (start_i)
        begin
          s_next.state    = SAR_RUN;
          s_next.bit_idx  = `ADC_MSB_INDEX;
          s_next.last_bit = short_i ? `ADC_SHORT_LAST_BIT : `ADC_FULL_LAST_BIT;
          s_next.div_cnt  = 6'h00;
          s_next.approx   = `ADC_MSB_TRIAL;
        end
      end
      SAR_RUN:
      begin
        s_next.div_cnt = s_reg.div_cnt + 6'h01;
        if (bit_en)
        begin
          s_next.div_cnt = 6'h00;
          if (!comp_keep_i)
            s_next.approx[s_reg.bit_idx] = 1'b0;
          if (s_reg.bit_idx == s_reg.last_bit)
          begin
            s_next.state = SAR_IDLE; // short cycle leaves low bits at zero
            s_next.done  = 1'b1;
          end
          else
          begin
            s_next.bit_idx = s_reg.bit_idx - 4'h1;
            s_next.approx[s_reg.bit_idx - 4'h1] = 1'b1;
          end
        end
      end
      default:
        s_next.state = SAR_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s_reg.state    <= SAR_IDLE;
      s_reg.bit_idx  <= 4'h0;
      s_reg.last_bit <= 4'h0;
      s_reg.div_cnt  <= 6'h00;
      s_reg.approx   <= `ADC_RESULT_RST;
      s_reg.done     <= 1'b0;
    end
    else
      s_reg <= s_next;
  end

  assign busy_o   = (s_reg.state == SAR_RUN);
  assign done_o   = s_reg.done;
  assign result_o = s_reg.approx;

endmodule // adc_sar_sequencer

// >>> adc_host_ctrl.sv
// converter host interface control: pin decode, conversion status, result steering, registers
// assumes host pins are synchronous to clk_i and an external tri-state pad resolves the data lines
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"

module adc_host_ctrl
  import adc_ctrl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        select_n_i,
  input  wire logic        strobe_i,
  input  wire logic        read_convert_i,
  input  wire logic        byte_select_short_cycle_i,
  input  wire logic        width_select_i,
  input  wire logic        comp_keep_i,
  output logic             conversion_in_progress_o,
  output logic [3:0]       result_upper_lines_o,
  output logic             result_upper_lines_oe_o,
  output logic [3:0]       result_middle_lines_o,
  output logic             result_middle_lines_oe_o,
  output logic [3:0]       result_lower_lines_o,
  output logic             result_lower_lines_oe_o,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [15:0]      reg_rdata_o,
  output logic             irq_o
);

  typedef struct packed
  {
    ctrl_state_e state;
    logic        rc_prev;
    logic        cmd_prev;
    logic        short_cycle;
    logic [5:0]  acq_cnt;
    result_t     result;
    logic        result_valid;
    logic        standalone;
    event_t      ev_status;
    event_t      ev_mask;
    logic [15:0] rdata;
  } ctl_s;

  ctl_s  c_reg;
  ctl_s  c_next;
  logic  addressed;
  logic  cmd_conv;
  logic  cmd_read;
  logic  fc_start;
  logic  sa_start;
  logic  start_req;
  logic  sar_start;
  logic  sar_done;
  logic  rd_act;
  result_t sar_result;
  event_t  ev_set;

  // register hit, shared by the write and read decoders
  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] offset);
    reg_hit = (addr == offset);
  endfunction

  // pin decode: commands act only when selected and strobed; a stand-alone start needs only read/convert falling
  assign addressed = !select_n_i && strobe_i;
  assign cmd_conv  = addressed && !read_convert_i;
  assign cmd_read  = addressed && read_convert_i;
  // full control starts on the rising edge of the command so a long strobe cannot retrigger
  assign fc_start  = !c_reg.standalone && cmd_conv && !c_reg.cmd_prev;
  assign sa_start  = c_reg.standalone && c_reg.rc_prev && !read_convert_i;
  assign start_req = fc_start || sa_start;
  // starts are taken only at rest; status high means busy, so later start requests are dropped
  assign sar_start = start_req && (c_reg.state == ST_IDLE);

  adc_sar_sequencer u_sar
  (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .start_i     (sar_start),
    .short_i     (byte_select_short_cycle_i),
    .comp_keep_i (comp_keep_i),
    .busy_o      (),
    .done_o      (sar_done),
    .result_o    (sar_result)
  );

  // events: done, accepted start, start refused while busy
  always_comb
  begin
    ev_set = `ADC_EV_RST;
    ev_set[`ADC_EV_DONE]    = (c_reg.state == ST_ACQUIRE) && (c_reg.acq_cnt == 6'(`ADC_ACQ_CYCLES - 1));
    ev_set[`ADC_EV_START]   = sar_start;
    ev_set[`ADC_EV_IGNORED] = start_req && (c_reg.state != ST_IDLE);
  end

  // control sequence and register file
  always_comb
  begin
    c_next = c_reg;
    c_next.rc_prev  = read_convert_i;
    c_next.cmd_prev = cmd_conv;
    c_next.rdata    = 16'h0000;
    case (c_reg.state)
      ST_IDLE:
      begin
        if (sar_start)
        begin
          c_next.state        = ST_CONVERT;
          c_next.short_cycle  = byte_select_short_cycle_i;
          c_next.result_valid = 1'b0;
        end
      end
      ST_CONVERT:
      begin
        if (sar_done)
        begin
          c_next.state        = ST_ACQUIRE;
          c_next.result       = sar_result;
          c_next.result_valid = 1'b1;
          c_next.acq_cnt      = 6'h00;
        end
      end
      ST_ACQUIRE:
      begin
        // status stays high through acquisition, reads are already open
        c_next.acq_cnt = c_reg.acq_cnt + 6'h01;
        if (ev_set[`ADC_EV_DONE])
          c_next.state = ST_IDLE;
      end
      default:
        c_next.state = ST_IDLE;
    endcase
    // software writes; write-one-clear loses to a set in the same cycle
    if (reg_wr_i && reg_hit(reg_addr_i, `ADC_REG_CTRL))
      c_next.standalone = reg_wdata_i[`ADC_CTRL_STANDALONE];
    if (reg_wr_i && reg_hit(reg_addr_i, `ADC_REG_MASK))
      c_next.ev_mask = reg_wdata_i[2:0];
    if (reg_wr_i && reg_hit(reg_addr_i, `ADC_REG_STATUS))
      c_next.ev_status = c_reg.ev_status & ~reg_wdata_i[2:0];
    c_next.ev_status = c_next.ev_status | ev_set;
    // reads answer in the next cycle, unmapped addresses read zero
    if (reg_rd_i)
    begin
      if (reg_hit(reg_addr_i, `ADC_REG_CTRL))
        c_next.rdata = {15'h0000, c_reg.standalone};
      else if (reg_hit(reg_addr_i, `ADC_REG_STATUS))
        c_next.rdata = {13'h0000, c_reg.ev_status};
      else if (reg_hit(reg_addr_i, `ADC_REG_MASK))
        c_next.rdata = {13'h0000, c_reg.ev_mask};
      else if (reg_hit(reg_addr_i, `ADC_REG_RESULT))
        c_next.rdata = {c_reg.result_valid, 3'h0, c_reg.result};
      else
        c_next.rdata = 16'h0000;
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      c_reg.state        <= ST_IDLE;
      c_reg.rc_prev      <= 1'b0;
      c_reg.cmd_prev     <= 1'b0;
      c_reg.short_cycle  <= 1'b0;
      c_reg.acq_cnt      <= 6'h00;
      c_reg.result       <= `ADC_RESULT_RST;
      c_reg.result_valid <= 1'b0;
      c_reg.standalone   <= `ADC_CTRL_RST;
      c_reg.ev_status    <= `ADC_EV_RST;
      c_reg.ev_mask      <= `ADC_EV_RST;
      c_reg.rdata        <= 16'h0000;
    end
    else
      c_reg <= c_next;
  end

  // status pin straight from the sequence register
  assign conversion_in_progress_o = (c_reg.state != ST_IDLE);

  // read gate: no result while a conversion runs, lines released otherwise
  assign rd_act = cmd_read && c_reg.result_valid && (c_reg.state != ST_CONVERT);

  // output steering; enables are combinational, data comes from the result register, the middle lines read zero in a lower-byte read
  assign result_upper_lines_oe_o  = rd_act && (width_select_i || !byte_select_short_cycle_i);
  assign result_middle_lines_oe_o = rd_act;
  assign result_lower_lines_oe_o  = rd_act && (width_select_i || byte_select_short_cycle_i);
  assign result_upper_lines_o     = c_reg.result[11:8];
  assign result_middle_lines_o    = (!width_select_i && byte_select_short_cycle_i) ? 4'h0 : c_reg.result[7:4];
  assign result_lower_lines_o     = c_reg.result[3:0];

  assign reg_rdata_o = c_reg.rdata;
  assign irq_o       = |(c_reg.ev_status & c_reg.ev_mask);

  // helper for the checks: cycles spent converting since the start
  logic [8:0] conv_cnt;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || sar_start)
      conv_cnt <= 9'h000;
    else if (c_reg.state == ST_CONVERT)
      conv_cnt <= conv_cnt + 9'h001;
  end

  localparam int FULL_CYC = `ADC_FULL_BITS * `ADC_BIT_CYCLES;
  localparam int SHORT_CYC = `ADC_SHORT_BITS * `ADC_BIT_CYCLES;
  // last acquisition cycle, counted from the first cycle after the sequencer's done
  localparam int ACQ_LAST = `ADC_ACQ_CYCLES - 1;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_full_len;
    sar_done && !c_reg.short_cycle |-> conv_cnt == 9'(FULL_CYC) && FULL_CYC <= `ADC_CONV12_MAX_CYCLES;
  endproperty
  a_full_len: assert property (p_full_len) else $error("full cycle length wrong");

  property p_short_len;
    sar_done && c_reg.short_cycle |-> conv_cnt == 9'(SHORT_CYC) && SHORT_CYC <= `ADC_CONV8_MAX_CYCLES;
  endproperty
  a_short_len: assert property (p_short_len) else $error("short cycle length wrong");

  property p_byte_low;
    rd_act && !width_select_i && !byte_select_short_cycle_i |->
      result_upper_lines_oe_o && !result_lower_lines_oe_o &&
      {result_upper_lines_o, result_middle_lines_o} == c_reg.result[11:4];
  endproperty
  a_byte_low: assert property (p_byte_low) else $error("high byte read wrong");

  property p_byte_high;
    rd_act && !width_select_i && byte_select_short_cycle_i |->
      !result_upper_lines_oe_o && result_lower_lines_oe_o && result_middle_lines_o == 4'h0 &&
      result_lower_lines_o == c_reg.result[3:0];
  endproperty
  a_byte_high: assert property (p_byte_high) else $error("low byte read wrong");

  property p_word;
    rd_act && width_select_i |-> result_upper_lines_oe_o && result_lower_lines_oe_o &&
      {result_upper_lines_o, result_middle_lines_o, result_lower_lines_o} == c_reg.result;
  endproperty
  a_word: assert property (p_word) else $error("word read wrong");

  property p_release;
    !(addressed && read_convert_i) |->
      !result_upper_lines_oe_o && !result_middle_lines_oe_o && !result_lower_lines_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("data lines driven outside a read");

  property p_fc_start;
    !c_reg.standalone && cmd_conv && !c_reg.cmd_prev && !conversion_in_progress_o |=>
      conversion_in_progress_o && c_reg.state == ST_CONVERT;
  endproperty
  a_fc_start: assert property (p_fc_start) else $error("convert command not taken");

  property p_sa_start;
    c_reg.standalone && $fell(read_convert_i) && c_reg.state == ST_IDLE |=> c_reg.state == ST_CONVERT;
  endproperty
  a_sa_start: assert property (p_sa_start) else $error("stand-alone start missed");

  property p_sts_end;
    sar_done |-> ##1 conversion_in_progress_o ##ACQ_LAST conversion_in_progress_o
      ##1 !conversion_in_progress_o;
  endproperty
  a_sts_end: assert property (p_sts_end) else $error("status did not fall after acquisition");

  property p_no_restart;
    c_reg.state == ST_CONVERT && !sar_done |=> c_reg.state == ST_CONVERT && $stable(c_reg.short_cycle)
      && !result_middle_lines_oe_o;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion disturbed");

  property p_acq_read;
    c_reg.state == ST_ACQUIRE && cmd_read |-> result_middle_lines_oe_o;
  endproperty
  a_acq_read: assert property (p_acq_read) else $error("read refused during acquisition");

  c_full: cover property (sar_start && !byte_select_short_cycle_i);
  c_short: cover property (sar_done && c_reg.short_cycle);
  c_standalone: cover property (c_reg.standalone && sar_start);
  c_byte_read: cover property (rd_act && !width_select_i && byte_select_short_cycle_i);

endmodule // adc_host_ctrl

// >>> adc_far_side_model.sv
// far side stand-in: the data pads as the host sees them, and the comparator verdicts
// assumes status rises one cycle after the start edge and bits are tried msb first
`timescale 1ns/1ps

module adc_far_side_model
(
  input  wire logic        clk_i,
  input  wire logic        busy_i,
  input  wire logic [11:0] target_i,
  input  wire logic [11:0] lines_i,
  input  wire logic [2:0]  oe_i,
  output logic             comp_keep_o,
  output logic [11:0]      bus_o
);
  logic [11:0] last_reg;
  logic [9:0]  slot_reg;
  int          idx;

  // remember what each group last drove and count cycles of the busy period
  always_ff @(posedge clk_i)
  begin
    for (int g = 0; g < 3; g++)
    begin
      if (oe_i[g])
        last_reg[g*4 +: 4] <= lines_i[g*4 +: 4];
    end
    slot_reg <= busy_i ? slot_reg + 10'h001 : 10'h000;
  end

  // a released group shows the inverse of its last value, so stale data never passes as fresh
  // the verdict changes mid slot, well clear of the sampling cycle at either end
  always_comb
  begin
    for (int g = 0; g < 3; g++)
      bus_o[g*4 +: 4] = oe_i[g] ? lines_i[g*4 +: 4] : ~last_reg[g*4 +: 4];
    idx = (slot_reg < 10'h014) ? 0 : (int'(slot_reg) - 20) / 40;
    comp_keep_o = (idx < 12) ? target_i[11 - idx] : 1'b0;
  end
endmodule // adc_far_side_model

// >>> tb_top.sv
// self-checking bench for the converter host control: starts, reads, registers, interrupt
// assumes a 50 MHz clock; the far side model plays comparator and data pads
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"

module tb_top
  import adc_ctrl_pkg::*;
;
  typedef struct packed
  {
    logic       sa;
    logic       sh;
    result_t    tgt;
    result_t    res;
    logic [2:0] mask;
  } row_s;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sel_n = 1'b1, stb = 1'b0, rc = 1'b0, bsel = 1'b0, wsel = 1'b0;
  logic        wr = 1'b0, rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, val;
  logic [11:0] tgt = 12'h000;
  wire         keep, busy, irq;
  wire  [3:0]  up, mid, low;
  wire  [2:0]  oe;
  wire  [11:0] bus;
  wire  [15:0] rdata;
  int          errors, check_count, n;
  // short cycles keep only the top eight bits
  row_s        rows [4] = '{'{1'b0, 1'b0, 12'hA5C, 12'hA5C, 3'h0}, '{1'b0, 1'b1, 12'h3C7, 12'h3C0, 3'h1},
                            '{1'b1, 1'b0, 12'h5A3, 12'h5A3, 3'h4}, '{1'b1, 1'b1, 12'hFFF, 12'hFF0, 3'h2}};
  logic [4:0]  idle_pins [4] = '{5'b11000, 5'b00000, 5'b11101, 5'b00101};

  adc_host_ctrl uut
  (
    .clk_i(clk), .sys_rst_i(rst), .select_n_i(sel_n), .strobe_i(stb), .read_convert_i(rc),
    .byte_select_short_cycle_i(bsel), .width_select_i(wsel), .comp_keep_i(keep),
    .conversion_in_progress_o(busy), .result_upper_lines_o(up), .result_upper_lines_oe_o(oe[2]),
    .result_middle_lines_o(mid), .result_middle_lines_oe_o(oe[1]), .result_lower_lines_o(low),
    .result_lower_lines_oe_o(oe[0]), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq)
  );

  adc_far_side_model far
  (
    .clk_i(clk), .busy_i(busy), .target_i(tgt), .lines_i({up, mid, low}), .oe_i(oe),
    .comp_keep_o(keep), .bus_o(bus)
  );

  // 50 MHz clock
  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // host pins in order: select_n, strobe, read/convert, byte select, width select
  task automatic pins(input logic [4:0] v);
    {sel_n, stb, rc, bsel, wsel} <= v;
  endtask

  // one register access; the read word stands only in the cycle after the strobe
  task automatic reg_rw(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 val = rdata;
  endtask

  // read in organization m (0 word, 1 upper byte, 2 lower byte); live 0 means lines must stay off
  task automatic read_chk(input int m, input result_t r, input logic live);
    logic [2:0]  eo;
    logic [11:0] ed, mk;
    pins({3'b011, m == 2, m == 0});
    eo = !live ? 3'b000 : (m == 0) ? 3'b111 : (m == 1) ? 3'b110 : 3'b011;
    ed = (m == 2) ? {8'h00, r[3:0]} : r;
    mk = {{4{eo[2]}}, {4{eo[1]}}, {4{eo[0]}}};
    #1;
    check("enables", 16'(oe), 16'(eo));
    check("data", 16'(bus & mk), 16'(ed & mk));
  endtask

  // start, then a refused read, a refused start and an acquisition read while busy
  task automatic convert(input row_s r);
    int len;
    // bit slots, then acquisition, plus the cycle in which the control takes the sequencer's done
    len = (r.sh ? `ADC_SHORT_BITS : `ADC_FULL_BITS) * `ADC_BIT_CYCLES + `ADC_ACQ_CYCLES + 1;
    @(posedge clk);
    tgt <= r.tgt;
    pins({1'b1, 1'b0, r.sa, r.sh, 1'b0});
    @(posedge clk);
    pins({r.sa, !r.sa, 1'b0, r.sh, 1'b0});
    @(posedge clk);
    pins(5'b10000);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n == 100 || n == len - 20)
        read_chk(0, r.res, n > 100);
      else
      begin
        pins(n == 200 ? {3'b010, !r.sh, 1'b0} : 5'b10000);
        #1;
      end
      if (n == 1)
        check("status rise", 16'(busy), 16'h0001);
    end while (busy === 1'b1 && n < 2000);
    check("busy length", 16'(n), 16'(len));
  endtask

  // watchdog: the tests need about 40 us, so 200 us means a hang
  initial
  begin
    #200000;
    errors++;
    conclude();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("reset status", {12'h000, busy, oe}, 16'h0000);
    check("reset irq", {rdata[14:0], irq}, 16'h0000);
    reg_rw(1'b0, `ADC_REG_RESULT, 16'h0000);
    check("reset result", val, 16'h0000);
    @(posedge clk);
    read_chk(0, 12'h000, 1'b0);
    // table of conversions, each read back in all three organizations
    foreach (rows[i])
    begin
      reg_rw(1'b1, `ADC_REG_CTRL, {15'h0000, rows[i].sa});
      reg_rw(1'b1, `ADC_REG_MASK, {13'h0000, rows[i].mask});
      convert(rows[i]);
      for (int m = 0; m < 3; m++)
      begin
        @(posedge clk);
        read_chk(m, rows[i].res, 1'b1);
      end
      @(posedge clk);
      pins(5'b10100); // read/convert stays high so no stand-alone start slips in
      reg_rw(1'b0, `ADC_REG_STATUS, 16'h0000);
      check("events", val, 16'h0007);
      check("irq", 16'(irq), 16'(|rows[i].mask));
      reg_rw(1'b1, `ADC_REG_STATUS, 16'h0007);
      reg_rw(1'b0, `ADC_REG_STATUS, 16'h0000);
      check("events cleared", {val[15:1], irq}, 16'h0000);
    end
    // register readback, an unmapped place and the last result word
    reg_rw(1'b1, `ADC_REG_CTRL, 16'h0000);
    reg_rw(1'b0, `ADC_REG_CTRL, 16'h0000);
    check("ctrl", val, 16'h0000);
    reg_rw(1'b0, `ADC_REG_MASK, 16'h0000);
    check("mask", val, 16'h0002);
    reg_rw(1'b0, 4'h2, 16'h0000);
    check("unmapped", val, 16'h0000);
    reg_rw(1'b0, `ADC_REG_RESULT, 16'h0000);
    check("result word", val, 16'h8FF0);
    // pin combinations missing select or strobe must neither start nor drive
    foreach (idle_pins[i])
    begin
      @(posedge clk);
      pins(idle_pins[i]);
      repeat (3) @(posedge clk);
      #1;
      check("no start", 16'(busy), 16'h0000);
      check("no drive", 16'(oe), 16'h0000);
    end
    // reset in mid-conversion: status drops and the half-made result is never offered
    @(posedge clk);
    pins(5'b01000);
    repeat (50) @(posedge clk);
    #1;
    check("busy before reset", 16'(busy), 16'h0001);
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    pins(5'b01100);
    @(posedge clk);
    #1;
    check("reset mid-run", {12'h000, busy, oe}, 16'h0000);
    reg_rw(1'b0, `ADC_REG_RESULT, 16'h0000);
    check("result after reset", val, 16'h0000);
    conclude();
  end
endmodule // tb_top
